// ### hdl/sac_adc_control.v
// successive-approximation converter control with an axi4-lite register port
//
// Decided for this implementation: the AXI4-Lite register port.
`timescale 1ns/1ps
`include "sac_consts.vh"

// How it works
// - enabled interrupt requested at every completion while complete bit is 0
// - with interrupts on, complete bit is writable selector
// - interrupts off: flag set, cleared by write/read
// - result read or control write drops request
// - reset clears flag, interrupt enable, continuous
// - continuous repeats conversions, else exactly one
// - five-bit channel picks port b or d pin
// - all-ones channel powers down; reset value
// - unused codes give undefined result; one reserved
// - two codes below off route references
// - wait mode runs on; interrupt wakes cpu
// - stop aborts conversion; resumes after stop
// - eight-bit result loaded at each completion
// - prescaler divides by 1,2,4,8 or 16
// - source bit: 1 bus clock, 0 crystal
// - control write starts 16-17 tick conversion
// - continuous results overwrite unread ones
// - selected channel pin forced to input
module sac_adc_control
(
	input wire aclk,
	input wire aresetn,
	input wire [7:0] s_axi_awaddr,
	input wire [2:0] s_axi_awprot,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [7:0] s_axi_araddr,
	input wire [2:0] s_axi_arprot,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	input wire crystal_ref_clock,
	input wire stop_mode,
	input wire comp_above,
	output reg [4:0] selected_analog_input,
	output reg analog_power_down,
	output reg high_reference_route,
	output reg low_reference_route,
	output reg sample_hold,
	output reg [7:0] sar_trial,
	output reg [7:0] port_b_force_input,
	output reg [6:0] port_d_force_input,
	output reg conv_irq
);

	// control register fields
	reg conv_complete_flag_r; // completion flag or interrupt selector
	reg conv_irq_enable_r; // interrupt enable
	reg continuous_select_r; // continuous mode
	reg [4:0] channel_select_r; // channel code
	reg [2:0] clock_prescale_r; // prescale code
	reg input_clock_source_r; // 1 bus clock, 0 crystal
	reg [7:0] result_r; // last conversion value

	// bus slave state
	reg aw_held_r; // write address captured
	reg w_held_r; // write data captured
	reg [7:0] aw_addr_r; // captured write address
	reg [7:0] w_data_r; // captured low write byte
	reg w_lane_r; // low byte lane enabled

	// conversion engine state
	localparam ST_IDLE = 2'h0; // nothing to do
	localparam ST_RUN = 2'h1; // sampling or approximating
	localparam ST_HALT = 2'h2; // frozen by stop mode
	reg [1:0] state_r; // engine state
	reg [3:0] tick_cnt_r; // converter ticks into the conversion
	reg [7:0] trial_r; // approximation word
	reg pending_r; // a conversion is owed after stop

	// crystal clock synchroniser and edge detect
	reg xtal_meta_r; // first stage only
	reg xtal_sync_r; // second stage
	reg xtal_prev_r; // edge detect history

	wire conv_tick; // converter clock tick from prescaler
	wire src_tick; // selected input clock tick
	wire wr_fire; // write both halves present
	wire rd_fire; // read address taken
	wire scr_write; // control register written
	wire res_read; // result register read
	wire done; // conversion finishes this cycle

	// decides whether a code is the power-off code
	function is_off;
		input [4:0] code;
		begin
			is_off = (code == `SAC_CHAN_POWER_OFF);
		end
	endfunction

	// true when the address hits a mapped register
	function is_mapped;
		input [7:0] addr;
		begin
			is_mapped = (addr == `SAC_OFS_STATUS_CONTROL) || (addr == `SAC_OFS_RESULT) ||
				(addr == `SAC_OFS_CLOCK_SELECT);
		end
	endfunction

	// crystal clock passes two flops before use
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			xtal_meta_r <= 1'b0;
			xtal_sync_r <= 1'b0;
			xtal_prev_r <= 1'b0;
		end
		else
		begin
			xtal_meta_r <= crystal_ref_clock;
			xtal_sync_r <= xtal_meta_r;
			xtal_prev_r <= xtal_sync_r;
		end
	end

	// source choice: bus clock ticks every cycle
	assign src_tick = input_clock_source_r ? 1'b1 : (xtal_sync_r & ~xtal_prev_r);

	// prescaler restarts with each status and control write, not between continuous conversions
	sac_prescale u_prescale
	(
		.aclk(aclk),
		.aresetn(aresetn),
		.src_tick(src_tick),
		.div_code(clock_prescale_r),
		.restart(scr_write),
		.conv_tick_r(conv_tick)
	);

	assign wr_fire = aw_held_r && w_held_r && !s_axi_bvalid;
	assign rd_fire = s_axi_arvalid && s_axi_arready;
	assign scr_write = wr_fire && w_lane_r && (aw_addr_r == `SAC_OFS_STATUS_CONTROL);
	assign res_read = rd_fire && (s_axi_araddr == `SAC_OFS_RESULT);
	assign done = (state_r == ST_RUN) && conv_tick && (tick_cnt_r == `SAC_LAST_TICK)
		&& !stop_mode;

	// write channels: address and data taken in either order
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_held_r <= 1'b0;
			w_held_r <= 1'b0;
			aw_addr_r <= 8'h00;
			w_data_r <= 8'h00;
			w_lane_r <= 1'b0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `SAC_RESP_OKAY;
		end
		else
		begin
			// ready only while the slot is free
			s_axi_awready <= !aw_held_r && !(s_axi_awvalid && s_axi_awready);
			s_axi_wready <= !w_held_r && !(s_axi_wvalid && s_axi_wready);
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_held_r <= 1'b1;
				aw_addr_r <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_held_r <= 1'b1;
				w_data_r <= s_axi_wdata[7:0];
				w_lane_r <= s_axi_wstrb[0];
			end
			// answer once both halves are in
			if (wr_fire)
			begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= is_mapped(aw_addr_r) ? `SAC_RESP_OKAY : `SAC_RESP_SLVERR;
				aw_held_r <= 1'b0;
				w_held_r <= 1'b0;
			end
			else if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	// read channel: one read at a time, data from a register
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= `SAC_RESP_OKAY;
		end
		else
		begin
			s_axi_arready <= !s_axi_rvalid && !rd_fire;
			if (rd_fire)
			begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= `SAC_RESP_OKAY;
				case (s_axi_araddr)
					`SAC_OFS_STATUS_CONTROL:
						s_axi_rdata <= {24'h00_0000, conv_complete_flag_r, conv_irq_enable_r,
							continuous_select_r, channel_select_r};
					`SAC_OFS_RESULT:
						s_axi_rdata <= {24'h00_0000, result_r};
					`SAC_OFS_CLOCK_SELECT:
						s_axi_rdata <= {24'h00_0000, clock_prescale_r, input_clock_source_r,
							4'h0};
					default:
					begin
						s_axi_rdata <= 32'h0000_0000;
						s_axi_rresp <= `SAC_RESP_SLVERR;
					end
				endcase
			end
			else if (s_axi_rvalid && s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
	end

	// control fields, flag and result
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			conv_complete_flag_r <= 1'b0;
			conv_irq_enable_r <= 1'b0;
			continuous_select_r <= 1'b0;
			channel_select_r <= `SAC_CHAN_RESET;
			clock_prescale_r <= `SAC_DIV_RESET;
			input_clock_source_r <= `SAC_SRC_RESET;
			result_r <= 8'h00;
		end
		else
		begin
			if (scr_write)
			begin
				conv_irq_enable_r <= w_data_r[`SAC_SC_IRQ_EN_BIT];
				continuous_select_r <= w_data_r[`SAC_SC_CONT_BIT];
				channel_select_r <= w_data_r[`SAC_SC_CHAN_HI:`SAC_SC_CHAN_LO];
			end
			if (wr_fire && w_lane_r && (aw_addr_r == `SAC_OFS_CLOCK_SELECT))
			begin
				clock_prescale_r <= w_data_r[`SAC_CK_DIV_HI:`SAC_CK_DIV_LO];
				input_clock_source_r <= w_data_r[`SAC_CK_SRC_BIT];
			end
			// every completion loads the result, read or not
			if (done)
				result_r <= {trial_r[7:1], comp_above};
			// flag behaviour depends on interrupt enable
			if (conv_irq_enable_r && !(scr_write && !w_data_r[`SAC_SC_IRQ_EN_BIT]))
			begin
				// writable selector, no completion meaning
				if (scr_write)
					conv_complete_flag_r <= w_data_r[`SAC_SC_COMPLETE_BIT];
			end
			else if (done && !(scr_write && w_data_r[`SAC_SC_IRQ_EN_BIT]))
				conv_complete_flag_r <= 1'b1;
			else if (scr_write && w_data_r[`SAC_SC_IRQ_EN_BIT])
				conv_complete_flag_r <= w_data_r[`SAC_SC_COMPLETE_BIT];
			else if (scr_write || res_read)
				conv_complete_flag_r <= 1'b0;
		end
	end

	// interrupt request: set wins over the withdraw
	always @(posedge aclk)
	begin
		if (!aresetn)
			conv_irq <= 1'b0;
		else if (done && conv_irq_enable_r && !conv_complete_flag_r)
			conv_irq <= 1'b1;
		else if (scr_write || res_read || !conv_irq_enable_r)
			conv_irq <= 1'b0;
	end

	// conversion engine: sample then eight approximation steps
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			state_r <= ST_IDLE;
			tick_cnt_r <= 4'h0;
			trial_r <= 8'h00;
			pending_r <= 1'b0;
		end
		else if (scr_write)
		begin
			// new setup abandons any running conversion
			tick_cnt_r <= 4'h0;
			trial_r <= 8'h00;
			pending_r <= !is_off(w_data_r[`SAC_SC_CHAN_HI:`SAC_SC_CHAN_LO]);
			if (is_off(w_data_r[`SAC_SC_CHAN_HI:`SAC_SC_CHAN_LO]))
				state_r <= ST_IDLE;
			else if (stop_mode)
				state_r <= ST_HALT;
			else
				state_r <= ST_RUN;
		end
		else
		begin
			case (state_r)
				ST_IDLE:
				begin
					tick_cnt_r <= 4'h0;
				end
				ST_RUN:
				begin
					if (stop_mode)
					begin
						// stop aborts the conversion in progress
						state_r <= ST_HALT;
						tick_cnt_r <= 4'h0;
						trial_r <= 8'h00;
					end
					else if (conv_tick)
					begin
						tick_cnt_r <= tick_cnt_r + 4'h1;
						if (tick_cnt_r == `SAC_SAMPLE_TICKS - 4'h1)
							trial_r <= 8'h80; // end of sampling, try msb
						else if (tick_cnt_r == `SAC_LAST_TICK)
						begin
							// finished: repeat only in continuous mode
							tick_cnt_r <= 4'h0;
							trial_r <= 8'h00;
							pending_r <= continuous_select_r;
							if (!continuous_select_r)
								state_r <= ST_IDLE;
						end
						else if (tick_cnt_r >= `SAC_SAMPLE_TICKS)
						begin
							// keep or drop the bit under test, try the next
							trial_r <= ((trial_r & ~(8'h80 >> (tick_cnt_r - `SAC_SAMPLE_TICKS)))
								| ({7'h00, comp_above} << (4'h7 - (tick_cnt_r - `SAC_SAMPLE_TICKS))))
								| (8'h40 >> (tick_cnt_r - `SAC_SAMPLE_TICKS));
						end
					end
				end
				ST_HALT:
				begin
					// resume the owed conversion once stop ends
					if (!stop_mode)
						state_r <= pending_r ? ST_RUN : ST_IDLE;
				end
				default:
					state_r <= ST_IDLE;
			endcase
		end
	end

	// analog-side and port-side outputs, all registered
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			selected_analog_input <= `SAC_CHAN_RESET;
			analog_power_down <= 1'b1;
			high_reference_route <= 1'b0;
			low_reference_route <= 1'b0;
			sample_hold <= 1'b0;
			sar_trial <= 8'h00;
			port_b_force_input <= 8'h00;
			port_d_force_input <= 7'h00;
		end
		else
		begin
			// unused and reserved codes still convert, value meaningless
			selected_analog_input <= channel_select_r;
			// stop level powers down at once, idle or running
			analog_power_down <= is_off(channel_select_r) || stop_mode;
			high_reference_route <= (channel_select_r == `SAC_CHAN_REF_HIGH);
			low_reference_route <= (channel_select_r == `SAC_CHAN_REF_LOW);
			// no sampling once stop is seen, even before the engine halts
			sample_hold <= (state_r == ST_RUN) && !stop_mode &&
				(tick_cnt_r < `SAC_SAMPLE_TICKS);
			sar_trial <= trial_r;
			// selected pin overrides port logic as an input
			port_b_force_input <= (channel_select_r <= `SAC_CHAN_PORTB_LAST) ?
				(8'h01 << channel_select_r[2:0]) : 8'h00;
			port_d_force_input <= ((channel_select_r > `SAC_CHAN_PORTB_LAST) &&
				(channel_select_r <= `SAC_CHAN_PORTD_LAST)) ?
				(7'h01 << channel_select_r[2:0]) : 7'h00;
		end
	end

endmodule

// ### hdl/sac_consts.vh
// register map, field layout, reset values and timing counts of the converter control
`ifndef SAC_CONSTS_VH
`define SAC_CONSTS_VH

// byte addresses on the register bus
`define SAC_ADDR_W 8
`define SAC_OFS_STATUS_CONTROL 8'h38
`define SAC_OFS_RESULT 8'h3C
`define SAC_OFS_CLOCK_SELECT 8'h40

// status and control field positions
`define SAC_SC_COMPLETE_BIT 7
`define SAC_SC_IRQ_EN_BIT 6
`define SAC_SC_CONT_BIT 5
`define SAC_SC_CHAN_HI 4
`define SAC_SC_CHAN_LO 0

// clock select field positions
`define SAC_CK_DIV_HI 7
`define SAC_CK_DIV_LO 5
`define SAC_CK_SRC_BIT 4

// reset values
`define SAC_CHAN_RESET 5'h1F
`define SAC_DIV_RESET 3'h0
`define SAC_SRC_RESET 1'b0

// channel codes
`define SAC_CHAN_PORTB_LAST 5'h07
`define SAC_CHAN_PORTD_LAST 5'h0E
`define SAC_CHAN_RESERVED 5'h1B
`define SAC_CHAN_REF_HIGH 5'h1D
`define SAC_CHAN_REF_LOW 5'h1E
`define SAC_CHAN_POWER_OFF 5'h1F

// conversion timing in converter clock ticks
`define SAC_SAMPLE_TICKS 4'h8
`define SAC_LAST_TICK 4'hF

// bus responses
`define SAC_RESP_OKAY 2'h0
`define SAC_RESP_SLVERR 2'h2

`endif

// ### hdl/sac_prescale.v
// converter clock prescaler: turns input clock ticks into converter clock ticks
`timescale 1ns/1ps
module sac_prescale
(
	input wire aclk,
	input wire aresetn,
	input wire src_tick, // one tick of the selected input clock
	input wire [2:0] div_code, // prescale code
	input wire restart, // realign the divider
	output reg conv_tick_r // one-cycle converter clock tick
);

	reg [3:0] div_cnt_r; // counts input ticks
	reg [3:0] last_cnt; // terminal count for the code

	// decode the divide ratio, top bit set means 16
	always @*
	begin
		case (div_code)
			3'h0: last_cnt = 4'h0;
			3'h1: last_cnt = 4'h1;
			3'h2: last_cnt = 4'h3;
			3'h3: last_cnt = 4'h7;
			default: last_cnt = 4'hF;
		endcase
	end

	// divide and emit one pulse per ratio
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			div_cnt_r <= 4'h0;
			conv_tick_r <= 1'b0;
		end
		else if (restart)
		begin
			div_cnt_r <= 4'h0;
			conv_tick_r <= 1'b0;
		end
		else if (src_tick)
		begin
			// divide ratio chosen by code
			if (div_cnt_r >= last_cnt)
			begin
				div_cnt_r <= 4'h0;
				conv_tick_r <= 1'b1;
			end
			else
			begin
				div_cnt_r <= div_cnt_r + 4'h1;
				conv_tick_r <= 1'b0;
			end
		end
		else
			conv_tick_r <= 1'b0;
	end

endmodule

// ### sim/sac_adc_control_sva.sv
// port checker of the converter control, bound into the design
`timescale 1ns/1ps
`include "sac_consts.vh"
module sac_adc_control_sva
(
	input wire aclk,
	input wire aresetn,
	input wire s_axi_awvalid,
	input wire s_axi_awready,
	input wire s_axi_wvalid,
	input wire s_axi_wready,
	input wire [1:0] s_axi_bresp,
	input wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire [7:0] s_axi_araddr,
	input wire s_axi_arvalid,
	input wire s_axi_arready,
	input wire [31:0] s_axi_rdata,
	input wire s_axi_rvalid,
	input wire s_axi_rready,
	input wire stop_mode,
	input wire [4:0] selected_analog_input,
	input wire analog_power_down,
	input wire high_reference_route,
	input wire low_reference_route,
	input wire sample_hold,
	input wire [7:0] port_b_force_input,
	input wire conv_irq
);
	// single clock domain, synchronous active-low reset
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	// responses frozen until the master takes them
	a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready
		|=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response not held");
	a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data not held");
	// read answered next cycle, no second address meanwhile
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready
		|=> s_axi_rvalid && !s_axi_arready) else $error("read answer late");
	a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
		&& s_axi_wready |-> ##[1:2] s_axi_bvalid) else $error("write answer late");
	// result read withdraws the request
	a_irq_drop: assert property (
		s_axi_arvalid && s_axi_arready && s_axi_araddr == `SAC_OFS_RESULT
		|-> ##[1:2] !conv_irq) else $error("request kept after result read");
	// stop mode halts the analog side; channel codes set power-down, reference routes and forced pin
	a_stop_idle: assert property (
		stop_mode [*2] |-> analog_power_down && !sample_hold) else $error("active in stop");
	a_power_off: assert property (
		(selected_analog_input == `SAC_CHAN_POWER_OFF) [*2]
		|-> analog_power_down && port_b_force_input == 8'h00) else $error("not powered down");
	a_ref_high: assert property (
		(selected_analog_input == `SAC_CHAN_REF_HIGH) [*2]
		|-> high_reference_route && !low_reference_route) else $error("high route wrong");
	a_ref_low: assert property (
		(selected_analog_input == `SAC_CHAN_REF_LOW) [*2]
		|-> low_reference_route && !high_reference_route) else $error("low route wrong");
	a_force_pin: assert property (
		(selected_analog_input <= `SAC_CHAN_PORTB_LAST) [*2]
		|-> port_b_force_input == (8'h01 << selected_analog_input[2:0]))
		else $error("wrong pin forced");
endmodule
bind sac_adc_control sac_adc_control_sva u_sac_adc_control_sva (.*);

// ### sim/sac_adc_control_tb.sv
// self-checking bench: register traffic, conversions, stop and power-off
`timescale 1ns/1ps
`include "sac_consts.vh"
`define CHK(g, e) \
	begin \
		num_checks++; \
		if ((g) !== (e)) \
		begin \
			n_mismatch++; \
			$display("wrong value at %0t: got %h expected %h", $time, g, e); \
		end \
	end
module sac_adc_control_tb;
	localparam logic [7:0] SC = `SAC_OFS_STATUS_CONTROL;
	localparam logic [7:0] RS = `SAC_OFS_RESULT;
	localparam logic [7:0] CK = `SAC_OFS_CLOCK_SELECT;
	localparam logic [1:0] OK = `SAC_RESP_OKAY;
	localparam logic [1:0] ER = `SAC_RESP_SLVERR;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h00;
	logic [2:0] s_axi_awprot = 3'h0;
	logic s_axi_awvalid = 1'b0;
	logic [31:0] s_axi_wdata = 32'h0000_0000;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_wvalid = 1'b0;
	logic s_axi_bready = 1'b0;
	logic [7:0] s_axi_araddr = 8'h00;
	logic [2:0] s_axi_arprot = 3'h0;
	logic s_axi_arvalid = 1'b0;
	logic s_axi_rready = 1'b0;
	logic stop_mode = 1'b0;
	logic comp_above = 1'b0;
	logic [2:0] xdiv = 3'h0; // crystal divider, one crystal period per 8 bus cycles
	wire logic crystal_ref_clock;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	logic [4:0] selected_analog_input;
	logic analog_power_down, high_reference_route, low_reference_route, sample_hold, conv_irq;
	logic [7:0] sar_trial, port_b_force_input;
	logic [6:0] port_d_force_input;
	logic [7:0] ckv [8] = '{8'h00, 8'h20, 8'h30, 8'h50, 8'h70, 8'h90, 8'hF0, 8'h10};
	int rt [8] = '{8, 16, 2, 4, 8, 16, 16, 1}; // bus cycles per converter tick
	int n_mismatch = 0;
	int num_checks = 0;
	int cyc = 0;
	int i;
	int n;
	sac_adc_control u_sac_adc_control (.*);
	assign crystal_ref_clock = xdiv[2];
	// 40 mhz bus clock
	initial
	begin
		forever #12.5 aclk = ~aclk;
	end
	// slow crystal and hang guard
	always @(posedge aclk)
	begin
		xdiv <= xdiv + 3'h1;
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			n_mismatch++;
			end_of_test();
		end
	end
	task end_of_test;
		begin
			$display("checks %0d mismatches %0d", num_checks, n_mismatch);
			if (n_mismatch == 0 && num_checks > 0)
				$display("All checks passed");
			else
				$display("Checks failed");
			$finish;
		end
	endtask
	// one register write, address and data offered together
	task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
		begin
			@(posedge aclk);
			s_axi_awaddr <= a;
			s_axi_wdata <= {24'h00_0000, d};
			s_axi_awvalid <= 1'b1;
			s_axi_wvalid <= 1'b1;
			s_axi_bready <= 1'b1;
			do
			begin
				@(posedge aclk);
				if (s_axi_awready === 1'b1)
					s_axi_awvalid <= 1'b0;
				if (s_axi_wready === 1'b1)
					s_axi_wvalid <= 1'b0;
			end
			while (s_axi_bvalid !== 1'b1);
			s_axi_bready <= 1'b0;
			`CHK(s_axi_bresp, er)
		end
	endtask
	// one register read with expected byte and response
	task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [1:0] er);
		begin
			@(posedge aclk);
			s_axi_araddr <= a;
			s_axi_arvalid <= 1'b1;
			s_axi_rready <= 1'b1;
			do
			begin
				@(posedge aclk);
				if (s_axi_arready === 1'b1)
					s_axi_arvalid <= 1'b0;
			end
			while (s_axi_rvalid !== 1'b1);
			s_axi_rready <= 1'b0;
			`CHK(s_axi_rdata, {24'h00_0000, e})
			`CHK(s_axi_rresp, er)
		end
	endtask
	// cycles until the interrupt request shows
	task automatic wirq(output int c);
		begin
			c = 0;
			while (conv_irq !== 1'b1 && c < 2000)
			begin
				@(posedge aclk);
				c++;
			end
		end
	endtask
	initial
	begin
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		rd(SC, 8'h1F, OK);
		`CHK(analog_power_down, 1'b1)
		rd(CK, 8'h00, OK);
		rd(8'h44, 8'h00, ER);
		wr(8'h44, 8'h5A, ER);
		// a write without the low byte lane leaves the register alone
		s_axi_wstrb <= 4'hE;
		wr(CK, 8'hF0, OK);
		s_axi_wstrb <= 4'hF;
		rd(CK, 8'h00, OK);
		// both sources, prescale codes 0 to 4 and 7, interrupt mode
		for (i = 0; i < 8; i++)
		begin
			wr(CK, ckv[i], OK);
			rd(CK, ckv[i], OK);
			comp_above <= i[0];
			wr(SC, 8'h45, OK);
			wirq(n);
			`CHK(n >= 16 * rt[i] - 2 && n <= 17 * rt[i] + 6, 1'b1)
			rd(SC, 8'h45, OK);
			rd(RS, i[0] ? 8'hFF : 8'h00, OK);
			`CHK(conv_irq, 1'b0)
		end
		// rewrite mid-conversion restarts the count
		wr(SC, 8'h45, OK);
		repeat (8) @(posedge aclk);
		wr(SC, 8'h45, OK);
		wirq(n);
		`CHK(n >= 14 && n <= 23, 1'b1)
		rd(RS, 8'hFF, OK);
		// flag mode, single conversion
		wr(SC, 8'h05, OK);
		repeat (40) @(posedge aclk);
		rd(SC, 8'h85, OK);
		`CHK(sar_trial, 8'h00)
		`CHK(selected_analog_input, 5'h05)
		`CHK(port_b_force_input, 8'h20)
		rd(RS, 8'hFF, OK);
		rd(SC, 8'h05, OK);
		repeat (40) @(posedge aclk);
		rd(SC, 8'h05, OK);
		wr(SC, 8'h05, OK);
		repeat (40) @(posedge aclk);
		wr(SC, 8'h05, OK);
		rd(SC, 8'h05, OK);
		// continuous mode on a port d pin
		wr(SC, 8'h29, OK);
		repeat (60) @(posedge aclk);
		rd(RS, 8'hFF, OK);
		comp_above <= 1'b0;
		repeat (60) @(posedge aclk);
		rd(SC, 8'hA9, OK);
		rd(RS, 8'h00, OK);
		`CHK(port_d_force_input, 7'h02)
		// stop halts, exit resumes
		stop_mode <= 1'b1;
		repeat (3) @(posedge aclk);
		`CHK(analog_power_down, 1'b1)
		`CHK(sar_trial, 8'h00)
		rd(RS, 8'h00, OK);
		repeat (40) @(posedge aclk);
		rd(SC, 8'h29, OK);
		stop_mode <= 1'b0;
		repeat (60) @(posedge aclk);
		rd(SC, 8'hA9, OK);
		// reference codes and power-off code
		for (i = 29; i < 32; i++)
		begin
			wr(SC, i[7:0], OK);
			repeat (2) @(posedge aclk);
			`CHK(high_reference_route, i == 29)
			`CHK(low_reference_route, i == 30)
			`CHK(analog_power_down, i == 31)
		end
		// second reset in mid-run
		wr(SC, 8'h65, OK);
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		rd(SC, 8'h1F, OK);
		end_of_test();
	end
endmodule
